// *** rtl/adc_ctl_cfg.svh ***
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL        12'h000
`define OFS_CFG         12'h004
`define OFS_PINEN1      12'h008
`define OFS_PINEN2      12'h00C
`define OFS_CMPVAL      12'h010
`define OFS_RESULT      12'h014
`define OFS_STATUS      12'h018
`define OFS_PWR         12'h01C
`define OFS_TICKMOD     12'h020
// CTRL fields
`define CTRL_CH_LSB     0
`define CTRL_CONT_BIT   5
`define CTRL_IEN_BIT    6
`define CTRL_HWT_BIT    7
`define CTRL_CMPEN_BIT  8
`define CTRL_CMPGE_BIT  9
// CFG fields
`define CFG_CLK_LSB     0
`define CFG_DIV_LSB     2
`define CFG_MODE_LSB    4
// PWR fields
`define PWR_BANDGAP_BUFFER_ENABLE_BIT    0
`define PWR_LOWVOLT_DETECT_ENABLE_BIT    1
`define PWR_LOWVOLT_DETECT_STOP_ENABLE_BIT   2
// Channel codes
`define CH_PIN_LAST     5'h05
`define CH_PIN8         5'h08
`define CH_PIN9         5'h09
`define CH_TEMP         5'h1A
`define CH_BANDGAP      5'h1B
`define CH_OFF          5'h1F
// Reset values
`define RST_CTRL        10'h01F
`define RST_TICKMOD     16'hFFFF
// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// *** rtl/adc_ctl_pkg.sv ***
package adc_ctl_pkg;
    typedef enum logic [1:0] {
        CLK_BUS     = 2'h0,
        CLK_BUS_DIV2 = 2'h1,
        CLK_ALT     = 2'h2,
        CLK_LOCAL   = 2'h3
    } clk_src_t;
    typedef enum logic [1:0] {
        FMT_8  = 2'h0,
        FMT_12 = 2'h1,
        FMT_10 = 2'h2
    } res_fmt_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_DONE = 2'h2
    } conv_state_t;
    typedef enum logic [1:0] {
        PM_RUN   = 2'h0,
        PM_WAIT  = 2'h1,
        PM_STOP3 = 2'h2
    } pwr_mode_t;
endpackage

// *** rtl/conv_clk_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
// Selects a conversion clock source and divides it into a one-cycle tick.
module conv_clk_gen
    import adc_ctl_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] src,
    input  wire logic [1:0] div,
    input  wire logic       alt_tick,
    input  wire logic       local_tick,
    input  wire logic       alt_allowed,
    output logic            conv_tick
);
    typedef struct packed {
        logic       half;
        logic [2:0] cnt;
        logic       tick;
    } ccg_state_t;
    ccg_state_t st;
    ccg_state_t next_st;
    logic       src_tick;

    always_comb begin
        next_st = st;
        // Four selectable sources
        case (clk_src_t'(src))
            CLK_BUS:      src_tick = 1'b1;
            CLK_BUS_DIV2: src_tick = st.half;
            CLK_ALT:      src_tick = alt_tick && alt_allowed;
            CLK_LOCAL:    src_tick = local_tick;
            default:      src_tick = 1'b0;
        endcase
        next_st.half = ~st.half;
        next_st.tick = 1'b0;
        if (src_tick) begin
            // Divide by 1, 2, 4 or 8
            if (st.cnt >= ((3'h1 << div) - 3'h1)) begin
                next_st.cnt  = 3'h0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign conv_tick = st.tick;
endmodule
`default_nettype wire

// *** rtl/trig_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser with rising-edge pulse out.
module trig_sync (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ts_state_t;
    ts_state_t st;
    ts_state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // One pulse per match event
    assign pulse = st.s2 & ~st.s3;
endmodule
`default_nettype wire

// *** rtl/adc_channel_clock_trigger_config.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_cfg.svh"
module adc_channel_clock_trigger_config
    import adc_ctl_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  pwr_mode,
    input  wire logic        external_reference_clock,
    input  wire logic        local_async_conv_clock,
    input  wire logic [15:0] tick_counter_value,
    input  wire logic        comp_out,
    output logic [4:0]       mux_sel,
    output logic             mux_route_en,
    output logic             temp_sensor_en,
    output logic             bandgap_sel,
    output logic             adc_power_on,
    output logic             sar_sample,
    output logic [11:0]      sar_trial,
    output logic             irq
);
    if (RES_BITS != 12) begin : g_res_check
        $error("RES_BITS must be 12");
    end

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [9:0]  ctrl;
        logic [5:0]  cfg;
        logic [7:0]  pinen1;
        logic [7:0]  pinen2;
        logic [11:0] cmpval;
        logic [11:0] result;
        logic        done;
        logic [2:0]  pwr;
        logic [15:0] tickmod;
        logic        match_lvl;
        conv_state_t state;
        logic [3:0]  bitpos;
        logic [11:0] sar;
        logic        cont_run;
        logic [4:0]  mux_sel;
        logic        route_en;
        logic        temp_en;
        logic        bg_sel;
        logic        pwr_on;
        logic        sample;
        logic        irq;
    } top_state_t;
    top_state_t st;
    top_state_t next_st;

    logic conv_tick;
    logic hw_start;
    logic [4:0] ch;
    logic pin_gate;
    logic run_allowed;
    logic sw_start;
    logic wr_go;
    logic cmp_true;
    logic [11:0] fmt_res;
    logic [31:0] rd_word;

    // ****************************************
    // Clock selection and trigger crossing
    // ****************************************
    // Alternate source is the reference clock; not usable in stop3
    conv_clk_gen u_clk (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .src         (st.cfg[`CFG_CLK_LSB +: 2]),
        .div         (st.cfg[`CFG_DIV_LSB +: 2]),
        .alt_tick    (external_reference_clock),
        .local_tick  (local_async_conv_clock),
        .alt_allowed (pwr_mode != PM_STOP3),
        .conv_tick   (conv_tick)
    );
    trig_sync u_trig (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (st.match_lvl),
        .pulse    (hw_start)
    );

    assign ch = st.ctrl[`CTRL_CH_LSB +: 5];
    // Pin codes gated by their enable bit; no third enable register
    always_comb begin
        pin_gate = 1'b0;
        if (ch <= `CH_PIN_LAST) begin
            pin_gate = st.pinen1[ch[2:0]];
        end else if (ch == `CH_PIN8 || ch == `CH_PIN9) begin
            pin_gate = st.pinen2[ch[2:0]];
        end
    end
    // Stop3 running requires both low-volt enables; stop1 does not exist
    assign run_allowed = (pwr_mode != PM_STOP3) ||
                         (st.pwr[`PWR_LOWVOLT_DETECT_ENABLE_BIT] && st.pwr[`PWR_LOWVOLT_DETECT_STOP_ENABLE_BIT]);
    assign cmp_true = st.ctrl[`CTRL_CMPGE_BIT] ? (st.sar >= st.cmpval) : (st.sar < st.cmpval);
    always_comb begin
        case (res_fmt_t'(st.cfg[`CFG_MODE_LSB +: 2]))
            FMT_8:   fmt_res = {4'h0, st.sar[11:4]};
            FMT_10:  fmt_res = {2'h0, st.sar[11:2]};
            default: fmt_res = st.sar;
        endcase
    end
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
    assign sw_start = wr_go && s_axi_awaddr == `OFS_CTRL && s_axi_wstrb[0];

    always_comb begin
        case (s_axi_araddr)
            `OFS_CTRL:    rd_word = {22'h0, st.ctrl};
            `OFS_CFG:     rd_word = {26'h0, st.cfg};
            `OFS_PINEN1:  rd_word = {24'h0, st.pinen1};
            `OFS_PINEN2:  rd_word = {24'h0, st.pinen2};
            `OFS_CMPVAL:  rd_word = {20'h0, st.cmpval};
            `OFS_RESULT:  rd_word = {20'h0, st.result};
            `OFS_STATUS:  rd_word = {29'h0, st.state, st.done};
            `OFS_PWR:     rd_word = {29'h0, st.pwr};
            `OFS_TICKMOD: rd_word = {16'h0, st.tickmod};
            default:      rd_word = 32'h0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.awready = 1'b0;
        next_st.wready  = 1'b0;
        next_st.arready = 1'b0;
        next_st.sample  = 1'b0;
        // Match level independent of tick interrupt, in any mode
        next_st.match_lvl = (tick_counter_value == st.tickmod);
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_go && !st.awready) begin
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = `RESP_OKAY;
            case (s_axi_awaddr)
                `OFS_CTRL: begin
                    next_st.ctrl = s_axi_wdata[9:0];
                    next_st.done = 1'b0;
                end
                `OFS_CFG:     next_st.cfg = s_axi_wdata[5:0];
                `OFS_PINEN1:  next_st.pinen1 = s_axi_wdata[7:0];
                `OFS_PINEN2:  next_st.pinen2 = s_axi_wdata[7:0];
                `OFS_CMPVAL:  next_st.cmpval = s_axi_wdata[11:0];
                `OFS_PWR:     next_st.pwr = s_axi_wdata[2:0];
                `OFS_TICKMOD: next_st.tickmod = s_axi_wdata[15:0];
                `OFS_RESULT, `OFS_STATUS: ;
                default: next_st.bresp = `RESP_SLVERR;
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid && !st.arready) begin
            next_st.arready = 1'b1;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = rd_word;
            next_st.rresp   = (s_axi_araddr > `OFS_TICKMOD || s_axi_araddr[1:0] != 2'h0) ?
                              `RESP_SLVERR : `RESP_OKAY;
            if (s_axi_araddr == `OFS_RESULT) begin
                next_st.done = 1'b0;
            end
        end

        // Converter sequencing
        case (st.state)
            ST_IDLE: begin
                if (((!st.ctrl[`CTRL_HWT_BIT] && st.cont_run) ||
                     (st.ctrl[`CTRL_HWT_BIT] && hw_start)) && ch != `CH_OFF) begin
                    next_st.state  = ST_CONV;
                    next_st.bitpos = 4'hB;
                    next_st.sar    = 12'h800;
                    next_st.sample = 1'b1;
                end
            end
            ST_CONV: begin
                // No decision before the comparator is powered
                if (conv_tick && run_allowed && st.pwr_on) begin
                    // One trial bit per tick, MSB first
                    next_st.sar[st.bitpos] = comp_out;
                    if (st.bitpos == 4'h0) begin
                        next_st.state = ST_DONE;
                    end else begin
                        next_st.bitpos = st.bitpos - 4'h1;
                        next_st.sar[st.bitpos - 4'h1] = 1'b1;
                    end
                end
            end
            ST_DONE: begin
                // Flag gated by compare when enabled
                if (!st.ctrl[`CTRL_CMPEN_BIT] || cmp_true) begin
                    next_st.result = fmt_res;
                    next_st.done   = 1'b1;
                end
                // Continuous keeps running unless the hardware trigger bit is set, then waits for each match; single goes idle
                next_st.cont_run = st.ctrl[`CTRL_CONT_BIT];
                next_st.state = ST_IDLE;
            end
            default: next_st.state = ST_IDLE;
        endcase
        // Write aborts, then starts on the channel just written unless that channel is off or the hardware trigger bit is set
        if (sw_start) begin
            next_st.cont_run = 1'b0;
            next_st.state    = ST_IDLE;
            if (s_axi_wdata[`CTRL_CH_LSB +: 5] != `CH_OFF && !s_axi_wdata[`CTRL_HWT_BIT]) begin
                next_st.state  = ST_CONV;
                next_st.bitpos = 4'hB;
                next_st.sar    = 12'h800;
                next_st.sample = 1'b1;
            end
        end
        if (ch == `CH_OFF) begin
            next_st.cont_run = 1'b0;
            if (st.state == ST_CONV) begin
                next_st.state = ST_IDLE;
            end
        end

        // Analog front-end selects; reserved codes route nothing
        next_st.mux_sel  = ch;
        next_st.route_en = pin_gate;
        next_st.temp_en  = (ch == `CH_TEMP);
        next_st.bg_sel   = (ch == `CH_BANDGAP) && st.pwr[`PWR_BANDGAP_BUFFER_ENABLE_BIT];
        next_st.pwr_on   = (ch != `CH_OFF) && (next_st.state != ST_IDLE);
        next_st.irq      = next_st.done && st.ctrl[`CTRL_IEN_BIT];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st         <= '0;
            st.ctrl    <= `RST_CTRL;
            st.tickmod <= `RST_TICKMOD;
            st.state   <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready  = st.awready;
    assign s_axi_wready   = st.wready;
    assign s_axi_bvalid   = st.bvalid;
    assign s_axi_bresp    = st.bresp;
    assign s_axi_arready  = st.arready;
    assign s_axi_rvalid   = st.rvalid;
    assign s_axi_rdata    = st.rdata;
    assign s_axi_rresp    = st.rresp;
    assign mux_sel        = st.mux_sel;
    assign mux_route_en   = st.route_en;
    assign temp_sensor_en = st.temp_en;
    assign bandgap_sel    = st.bg_sel;
    assign adc_power_on   = st.pwr_on;
    assign sar_sample     = st.sample;
    assign sar_trial      = st.sar;
    assign irq            = st.irq;

    // ****************************************
    // Assertions
    // ****************************************
    property p_off_isolates;
        @(posedge sys_clk) disable iff (!rst_b)
        (ch == `CH_OFF) |=> !mux_route_en && !adc_power_on;
    endproperty
    a_off_isolates: assert property (p_off_isolates) else $error("off code not isolated");
    property p_temp_sel;
        @(posedge sys_clk) disable iff (!rst_b)
        (ch == `CH_TEMP) |=> temp_sensor_en;
    endproperty
    a_temp_sel: assert property (p_temp_sel) else $error("temp sensor not selected");
    property p_bg_gate;
        @(posedge sys_clk) disable iff (!rst_b)
        bandgap_sel |-> $past(st.pwr[`PWR_BANDGAP_BUFFER_ENABLE_BIT]);
    endproperty
    a_bg_gate: assert property (p_bg_gate) else $error("bandgap without buffer");
    property p_route_gate;
        @(posedge sys_clk) disable iff (!rst_b)
        mux_route_en |-> $past(pin_gate);
    endproperty
    a_route_gate: assert property (p_route_gate) else $error("pin routed while disabled");
    sequence s_hw_fire;
        st.state == ST_IDLE && st.ctrl[`CTRL_HWT_BIT] && hw_start && ch != `CH_OFF;
    endsequence
    property p_hw_start;
        @(posedge sys_clk) disable iff (!rst_b)
        s_hw_fire ##0 !sw_start |=> st.state == ST_CONV && sar_sample;
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("match did not start");
    property p_one_start;
        @(posedge sys_clk) disable iff (!rst_b)
        hw_start |=> !hw_start;
    endproperty
    a_one_start: assert property (p_one_start) else $error("double trigger");
    property p_single_idle;
        @(posedge sys_clk) disable iff (!rst_b)
        st.state == ST_DONE && !st.ctrl[`CTRL_CONT_BIT] |=> !st.cont_run;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single did not stop");
    property p_irq;
        @(posedge sys_clk) disable iff (!rst_b)
        irq |-> st.done;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
endmodule
`default_nettype wire

// *** verification/analog_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Analog front end seen by the converter
// ****************************************
module analog_side_model (
    input  wire logic        sys_clk,
    input  wire logic        adc_power_on,
    input  wire logic [11:0] sar_trial,
    input  wire logic [11:0] level,
    output logic             comp_out,
    output logic             ext_ref_clk,
    output logic             local_clk
);
    logic [1:0] div3 = 2'h0;
    logic       flip = 1'b0;
    // Sources run free in every power mode
    always @(posedge sys_clk) begin
        div3 <= (div3 == 2'h2) ? 2'h0 : div3 + 2'h1;
        flip <= ~flip;
    end
    assign ext_ref_clk = (div3 == 2'h0);
    assign local_clk = flip;
    // Unpowered comparator decides nothing useful, so it flips
    assign comp_out = adc_power_on ? (sar_trial <= level) : flip;
endmodule
`default_nettype wire

// *** verification/adc_channel_clock_trigger_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_cfg.svh"
module adc_channel_clock_trigger_config_tb_top
    import adc_ctl_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        rst_b;
    logic [11:0] s_axi_awaddr, s_axi_araddr, sar_trial, level, v;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pwr_mode, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ok, ien;
    logic        external_reference_clock, local_async_conv_clock, comp_out, irq;
    logic [15:0] tick_counter_value;
    logic [4:0]  mux_sel;
    logic        mux_route_en, temp_sensor_en, bandgap_sel, adc_power_on, sar_sample;
    int          errors = 0;
    int          check_count = 0;
    int          starts = 0;
    int          s0;
    int          expq[$];
    logic [31:0] seed = 32'h5A477605;

    adc_channel_clock_trigger_config #(.RES_BITS(12)) u_dut (
        .sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pwr_mode, .external_reference_clock, .local_async_conv_clock, .tick_counter_value, .comp_out,
        .mux_sel, .mux_route_en, .temp_sensor_en, .bandgap_sel, .adc_power_on, .sar_sample,
        .sar_trial, .irq);
    analog_side_model u_analog (.sys_clk, .adc_power_on, .sar_trial, .level, .comp_out,
        .ext_ref_clk(external_reference_clock), .local_clk(local_async_conv_clock));

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (sar_sample === 1'b1) starts <= starts + 1;

    // ****************************************
    // Tasks and reference model
    // ****************************************
    function automatic logic [11:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[11:0];
    endfunction

    function automatic int model(input int lv, input logic [1:0] f);
        if (f == FMT_12) return lv;
        if (f == FMT_10) return lv >> 2;
        return lv >> 4;
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Registered decode trails the write by a cycle or two
    task automatic ctl(input logic [9:0] c);
        wr(`OFS_CTRL, {22'h0, c});
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic conv(input logic [4:0] ch, input logic [5:0] cfg, input logic [9:0] c, input logic [11:0] lv);
        level <= lv;
        ien = c[`CTRL_IEN_BIT];
        wr(`OFS_CFG, {26'h0, cfg});
        ctl(c | {5'h0, ch});
        expq.push_back(model(lv, cfg[5:4]));
    endtask

    task automatic finish_conv(input logic want);
        ok = 1'b0;
        repeat (want ? 150 : 30) if (!ok) begin
            rd(`OFS_STATUS);
            ok = d[0];
        end
        chk("done", ok, want);
        chk("irq", irq, want & ien);
        if (want) begin
            rd(`OFS_RESULT);
            chk("result", d, expq.pop_front());
            chk("irq_clear", irq, 1'b0);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, tick_counter_value, level, pwr_mode} = '0;
        s_axi_wstrb = 4'hF;
        rst_b = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(`OFS_CTRL);
        chk("ctrl_reset", d, 32'h1F);
        chk("power_reset", adc_power_on, 1'b0);
        rd(`OFS_TICKMOD);
        chk("tickmod_reset", d, 32'hFFFF);
        rd(12'h024);
        chk("pinen3_resp", r, `RESP_SLVERR);
        chk("pinen3_data", d, 32'h0);
        wr(12'h024, 32'h1);
        chk("pinen3_wresp", r, `RESP_SLVERR);
        wr(`OFS_PINEN1, 32'h3F);
        wr(`OFS_PINEN2, 32'h3);
        chk("pinen2_wresp", r, `RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            conv(5'(i < 6 ? i : i + 2), {2'(i % 3), i[2:1], i[1:0]}, 10'h0, v);
            chk("mux_sel", mux_sel, 5'(i < 6 ? i : i + 2));
            chk("route_en", mux_route_en, 1'b1);
            finish_conv(1'b1);
        end
        s0 = starts;
        repeat (40) @(posedge sys_clk);
        chk("single_idle", starts, s0);
        wr(`OFS_PINEN1, 32'h0);
        ctl(10'h000);
        chk("route_gated", mux_route_en, 1'b0);
        ctl(10'h01A);
        chk("temp_sel", temp_sensor_en, 1'b1);
        ctl(10'h01B);
        chk("bandgap_off", bandgap_sel, 1'b0);
        wr(`OFS_PWR, 32'h1);
        ctl(10'h01B);
        chk("bandgap_on", bandgap_sel, 1'b1);
        ctl(10'h01F);
        s0 = starts;
        repeat (40) @(posedge sys_clk);
        chk("off_power", adc_power_on, 1'b0);
        chk("off_isolate", {mux_route_en, temp_sensor_en, bandgap_sel}, 3'h0);
        chk("off_starts", starts, s0);
        wr(`OFS_PINEN1, 32'h1);
        v = rnd();
        wr(`OFS_CMPVAL, {20'h0, v});
        conv(5'h0, 6'h10, 10'h340, v);
        finish_conv(1'b1);
        conv(5'h0, 6'h10, 10'h100, v);
        finish_conv(1'b0);
        expq.delete();
        s0 = starts;
        conv(5'h0, 6'h10, 10'h020, v);
        repeat (60) @(posedge sys_clk);
        chk("cont_runs", starts - s0 > 2, 1'b1);
        finish_conv(1'b1);
        ctl(10'h01F);
        s0 = starts;
        repeat (40) @(posedge sys_clk);
        chk("cont_stop", starts, s0);
        wr(`OFS_PWR, 32'h0);
        pwr_mode <= PM_STOP3;
        // Bus clock only: alternate source is not used in stop3
        conv(5'h0, 6'h10, 10'h0, rnd());
        finish_conv(1'b0);
        pwr_mode <= PM_RUN;
        finish_conv(1'b1);
        wr(`OFS_PWR, 32'h6);
        wr(`OFS_TICKMOD, 32'h0100);
        for (int m = 0; m < 3; m++) begin
            pwr_mode <= 2'(m);
            conv(5'h0, m == 1 ? 6'h12 : 6'h10, 10'h080, rnd());
            s0 = starts;
            tick_counter_value <= 16'h0100;
            repeat (8) @(posedge sys_clk);
            tick_counter_value <= 16'h0101;
            repeat (8) @(posedge sys_clk);
            chk("hw_starts", starts - s0, 1);
            finish_conv(1'b1);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
